// ==== include/eph_pkg.sv ====
// package: constants, modes and carriers of the eprom programming handshake
package eph_pkg;
    // port width of each of the two programming ports
    localparam int PORT_W = 8;
    // mode-select codes
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_SLAVE = 2'h1;
    localparam logic [1:0] MODE_CFG = 2'h2;
    // timing at 40 MHz (25 ns)
    localparam int CLK_NS = 25;
    localparam int STROBE_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_MAX_NS = 10000;
    localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_NS;
    localparam int PROG_NS = 2000;
    localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;
    // command code, not used: an auto session ends on image_last
    localparam logic [15:0] CMD_DONE = 16'hFFFF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        EPH_AM_IDLE = 2'b00,
        EPH_AM_ADDR = 2'b01,
        EPH_AM_DATA = 2'b10,
        EPH_AM_DONE = 2'b11
    } eph_am_state_t;

    // one word placed on, or taken from, the two ports
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } eph_word_t;

    // one programming request handed to the array
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } eph_req_t;
endpackage : eph_pkg

// ==== hdl/eph_pulse_timer.sv ====
// pulse timer: counts cycles a level is held, flags when over a limit
`timescale 1ns/1ps
module eph_pulse_timer #(
    parameter int LIMIT = 400,
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic level,
    output logic over
);
    logic [W-1:0] count;

    // count while level is high, restart when it drops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (!level) begin
            count <= '0;
        end else if (!over) begin
            count <= count + W'(1);
        end
    end

    assign over = (count >= W'(LIMIT));
endmodule : eph_pulse_timer

// ==== hdl/eph_program_handshake.sv ====
// top: eprom programming handshake, master (auto) and slave ends
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
module eph_program_handshake #(
    parameter int PULSE_MAX = eph_pkg::PULSE_MAX_CYC,
    parameter int PROG_TIME = eph_pkg::PROG_CYC,
    parameter logic [3:0] VERIFY_LANE = 4'h0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ext_access_select,
    input wire logic [1:0] burn_mode_select,
    // two 8-bit programming ports, split into in/out/enable (low=drive)
    input wire logic [7:0] port_lo_in,
    input wire logic [7:0] port_hi_in,
    output logic [7:0] port_lo_out,
    output logic [7:0] port_hi_out,
    output logic [7:0] port_lo_oe_n,
    output logic [7:0] port_hi_oe_n,
    // slave-side strobes (inputs), master-side strobes (outputs)
    input wire logic slave_addr_strobe,
    input wire logic slave_data_strobe,
    output logic master_addr_strobe,
    output logic master_data_strobe,
    // auto-mode image source: next address/data to burn
    input wire logic [15:0] image_addr,
    input wire logic [15:0] image_data,
    input wire logic image_last,
    output logic image_next,
    // array interface: write request and readback result
    output eph_pkg::eph_req_t array_req,
    output logic array_wr,
    input wire logic [15:0] array_rdata,
    // status pins
    output logic burn_active_n,
    output logic burn_pass,
    output logic byte_verify_ok,
    output logic pulse_overrun_n
);
    //------------------------------------------------------------------
    // mode decode
    //------------------------------------------------------------------
    logic prog_en;
    logic is_auto;
    logic is_slave;
    logic is_cfg;
    logic slave_like;

    // programming only while access select held at programming level
    assign prog_en = ext_access_select;
    assign is_auto = prog_en && (burn_mode_select == eph_pkg::MODE_AUTO);
    assign is_slave = prog_en && (burn_mode_select == eph_pkg::MODE_SLAVE);
    assign is_cfg = prog_en && (burn_mode_select == eph_pkg::MODE_CFG);
    assign slave_like = is_slave || is_cfg;

    //------------------------------------------------------------------
    // strobe edge detection (inputs taken as synchronous)
    //------------------------------------------------------------------
    logic addr_strobe_d;
    logic data_strobe_d;
    logic addr_fall;
    logic data_fall;

    // previous strobe levels; idle high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_strobe_d <= 1'b1;
            data_strobe_d <= 1'b1;
        end else begin
            addr_strobe_d <= slave_addr_strobe;
            data_strobe_d <= slave_data_strobe;
        end
    end

    assign addr_fall = addr_strobe_d && !slave_addr_strobe;
    assign data_fall = data_strobe_d && !slave_data_strobe;

    //------------------------------------------------------------------
    // slave capture: latch the ports on each falling strobe
    //------------------------------------------------------------------
    eph_pkg::eph_word_t slave_addr;
    eph_pkg::eph_word_t slave_data;
    logic slave_wr;
    logic slave_cmp;
    logic slave_fail;

    // address needs to be stable before the edge, so sample at it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slave_addr <= eph_pkg::WORD_ZERO;
        end else if (slave_like && addr_fall) begin
            slave_addr <= {port_hi_in, port_lo_in};
        end
    end

    // data latched and held for the programming pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slave_data <= eph_pkg::WORD_ZERO;
        end else if (slave_like && data_fall) begin
            slave_data <= {port_hi_in, port_lo_in};
        end
    end

    // one write per data strobe, compare a cycle later
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slave_wr <= 1'b0;
            slave_cmp <= 1'b0;
        end else begin
            slave_wr <= slave_like && data_fall;
            slave_cmp <= slave_wr;
        end
    end

    // per-byte verify: high when readback matches
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_verify_ok <= 1'b0;
        end else if (!slave_like || data_fall) begin
            byte_verify_ok <= 1'b0;
        end else if (slave_cmp) begin
            byte_verify_ok <= (array_rdata == slave_data);
        end
    end

    // sticky failure across the whole slave session
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slave_fail <= 1'b0;
        end else if (!prog_en) begin
            slave_fail <= 1'b0;
        end else if (slave_cmp && array_rdata != slave_data) begin
            slave_fail <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // overrun: data strobe held low too long
    //------------------------------------------------------------------
    logic pulse_over;

    eph_pulse_timer #(
        .LIMIT(PULSE_MAX),
        .W(eph_pkg::CNT_W)
    ) u_pulse (
        .clk(clk),
        .nrst(nrst),
        .level(is_slave && !slave_data_strobe),
        .over(pulse_over)
    );

    // stays low until the next data strobe begins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pulse_overrun_n <= 1'b1;
        end else if (!is_slave || data_fall) begin
            pulse_overrun_n <= 1'b1;
        end else if (pulse_over) begin
            pulse_overrun_n <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // auto master sequencer
    //------------------------------------------------------------------
    eph_pkg::eph_am_state_t am_state;
    eph_pkg::eph_am_state_t next_am_state;
    logic [eph_pkg::CNT_W-1:0] am_cnt;
    logic am_phase_end;
    logic am_fail;
    logic am_last;

    // strobe held low for the strobe width, then data gets pulse time
    assign am_phase_end = (am_state == eph_pkg::EPH_AM_ADDR)
        ? (am_cnt >= eph_pkg::CNT_W'(eph_pkg::STROBE_CYC))
        : (am_cnt >= eph_pkg::CNT_W'(PROG_TIME));

    // next state
    always_comb begin
        next_am_state = am_state;
        unique case (am_state)
            eph_pkg::EPH_AM_IDLE: begin
                if (is_auto) begin
                    next_am_state = eph_pkg::EPH_AM_ADDR;
                end
            end
            eph_pkg::EPH_AM_ADDR: begin
                if (am_phase_end) begin
                    next_am_state = eph_pkg::EPH_AM_DATA;
                end
            end
            eph_pkg::EPH_AM_DATA: begin
                if (am_phase_end) begin
                    // idle gap lets the source advance before the address
                    next_am_state = am_last ? eph_pkg::EPH_AM_DONE
                                            : eph_pkg::EPH_AM_IDLE;
                end
            end
            // done holds until the mode exit below
            eph_pkg::EPH_AM_DONE: next_am_state = am_state;
        endcase
        // leaving auto mode aborts any session
        if (!is_auto) begin
            next_am_state = eph_pkg::EPH_AM_IDLE;
        end
    end

    // state, phase counter, and last-word flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            am_state <= eph_pkg::EPH_AM_IDLE;
            am_cnt <= '0;
            am_last <= 1'b0;
        end else begin
            am_state <= next_am_state;
            if (next_am_state != am_state) begin
                am_cnt <= '0;
            end else begin
                am_cnt <= am_cnt + eph_pkg::CNT_W'(1);
            end
            if (am_state == eph_pkg::EPH_AM_IDLE) begin // next is address
                am_last <= image_last;
            end
        end
    end

    // ask the image source for the next word as each word finishes
    assign image_next = (am_state == eph_pkg::EPH_AM_DATA) && am_phase_end;

    // master strobes: low during their phase, falling marks valid
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            master_addr_strobe <= 1'b1;
            master_data_strobe <= 1'b1;
        end else begin
            master_addr_strobe <= (next_am_state != eph_pkg::EPH_AM_ADDR);
            master_data_strobe <= (next_am_state != eph_pkg::EPH_AM_DATA);
        end
    end

    // port drive: address then data; slaves answer on own lane
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_lo_out <= 8'hFF;
            port_hi_out <= 8'hFF;
            port_lo_oe_n <= 8'hFF;
            port_hi_oe_n <= 8'hFF;
        end else if (next_am_state == eph_pkg::EPH_AM_ADDR) begin
            {port_hi_out, port_lo_out} <= image_addr;
            port_lo_oe_n <= 8'h00;
            port_hi_oe_n <= 8'h00;
        end else if (next_am_state == eph_pkg::EPH_AM_DATA) begin
            {port_hi_out, port_lo_out} <= image_data;
            port_lo_oe_n <= 8'h00;
            port_hi_oe_n <= 8'h00;
        end else if (is_slave && slave_cmp) begin
            // open-drain style: pull own lane low on failure only
            {port_hi_out, port_lo_out} <= ~(16'h0001 << VERIFY_LANE);
            {port_hi_oe_n, port_lo_oe_n} <= ~(16'h0001 << VERIFY_LANE)
                | {16{array_rdata == slave_data}};
        end else if (!is_slave) begin
            port_lo_oe_n <= 8'hFF;
            port_hi_oe_n <= 8'hFF;
        end
    end

    // auto session failure: any slave lane low after a data burn
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            am_fail <= 1'b0;
        end else if (!is_auto) begin
            am_fail <= 1'b0;
        end else if (image_next
                     && {port_hi_in, port_lo_in} != image_data) begin
            am_fail <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // array write request
    //------------------------------------------------------------------
    // slave and config modes burn on the data strobe; auto mode writes no copy of its own
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            array_req <= '0;
            array_wr <= 1'b0;
        end else begin
            array_wr <= slave_like && data_fall;
            if (slave_like && data_fall) begin
                array_req <= {slave_addr, port_hi_in, port_lo_in};
            end
        end
    end

    //------------------------------------------------------------------
    // status pins
    //------------------------------------------------------------------
    // follows the state, not the next state, so it rises with pass valid
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            burn_active_n <= 1'b1;
        end else begin
            burn_active_n <= !(is_auto
                && am_state != eph_pkg::EPH_AM_DONE);
        end
    end

    // pass: auto is low-true at done, slave is high-true
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            burn_pass <= 1'b1;
        end else if (is_auto) begin
            burn_pass <= !(am_state == eph_pkg::EPH_AM_DONE && !am_fail);
        end else if (is_slave) begin
            burn_pass <= !slave_fail;
        end else begin
            burn_pass <= 1'b1;
        end
    end
endmodule : eph_program_handshake

// ==== test/eph_handshake_assertions.sv ====
// checker: port-level assertions of the programming handshake
`timescale 1ns/1ps
module eph_handshake_checker #(
    parameter int PULSE_MAX = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] burn_mode_select,
    input wire logic [7:0] port_lo_in,
    input wire logic [7:0] port_hi_in,
    input wire logic [7:0] port_lo_out,
    input wire logic [7:0] port_lo_oe_n,
    input wire logic slave_data_strobe,
    input wire logic master_addr_strobe,
    input wire logic master_data_strobe,
    input wire eph_pkg::eph_req_t array_req,
    input wire logic array_wr,
    input wire logic [15:0] array_rdata,
    input wire logic burn_active_n,
    input wire logic byte_verify_ok,
    input wire logic pulse_overrun_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    //------------------------------------------------------------------
    // helper logic
    //------------------------------------------------------------------
    logic is_slave; // slave mode selected
    logic [15:0] low_cnt; // cycles the data strobe has been low
    assign is_slave = burn_mode_select == eph_pkg::MODE_SLAVE;
    // saturating count, so a stuck strobe cannot wrap back to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= 16'h0000;
        end else if (is_slave && !slave_data_strobe) begin
            low_cnt <= (low_cnt == 16'hFFFF) ? low_cnt : low_cnt + 16'h0001;
        end else begin
            low_cnt <= 16'h0000;
        end
    end
    //------------------------------------------------------------------
    // sequences and assertions
    //------------------------------------------------------------------
    sequence s_data_fall;
        is_slave && $fell(slave_data_strobe);
    endsequence
    sequence s_master_data;
        !master_data_strobe && !$past(master_data_strobe);
    endsequence
    a_strobe_idle_other: assert property (
        (burn_mode_select != eph_pkg::MODE_AUTO)[*2]
        |-> master_addr_strobe && master_data_strobe)
        else $error("master strobe active outside auto mode");
    a_strobes_exclusive: assert property (
        !(!master_addr_strobe && !master_data_strobe))
        else $error("both master strobes low");
    a_addr_drives_ports: assert property (
        !master_addr_strobe |-> port_lo_oe_n == 8'h00)
        else $error("port not driven during address phase");
    a_data_held: assert property (
        s_master_data |-> $stable(port_lo_out) && $stable(port_lo_oe_n))
        else $error("port changed during data phase");
    a_write_follows: assert property (
        s_data_fall |-> ##1 array_wr)
        else $error("no array write after data strobe");
    a_write_data: assert property (
        s_data_fall |-> ##1 array_req.data == $past({port_hi_in, port_lo_in}))
        else $error("array data differs from latched port");
    a_verify_clear: assert property (
        s_data_fall |-> ##1 !byte_verify_ok)
        else $error("byte verify not cleared at strobe");
    a_verify_good: assert property (
        s_data_fall ##2 (array_rdata == array_req.data) |-> ##[0:1] byte_verify_ok)
        else $error("byte verify missing on good readback");
    a_overrun_flag: assert property (
        low_cnt >= PULSE_MAX + 2 |-> !pulse_overrun_n)
        else $error("overlong pulse not flagged");
    a_overrun_clear: assert property (
        s_data_fall |-> ##2 pulse_overrun_n)
        else $error("overrun flag not cleared by new pulse");
    a_active_auto: assert property (
        !master_addr_strobe || !master_data_strobe |-> !burn_active_n)
        else $error("active indicator high while burning");
endmodule : eph_handshake_checker

bind eph_program_handshake eph_handshake_checker #(
    .PULSE_MAX(PULSE_MAX)
) u_chk (
    .clk(clk), .nrst(nrst), .burn_mode_select(burn_mode_select),
    .port_lo_in(port_lo_in), .port_hi_in(port_hi_in),
    .port_lo_out(port_lo_out), .port_lo_oe_n(port_lo_oe_n),
    .slave_data_strobe(slave_data_strobe),
    .master_addr_strobe(master_addr_strobe),
    .master_data_strobe(master_data_strobe), .array_req(array_req),
    .array_wr(array_wr), .array_rdata(array_rdata),
    .burn_active_n(burn_active_n), .byte_verify_ok(byte_verify_ok),
    .pulse_overrun_n(pulse_overrun_n)
);

// ==== test/eph_far_model.sv ====
// far-side model: programming master in slave mode, slave in auto mode
`timescale 1ns/1ps
module eph_far_model (
    input wire logic clk,
    input wire logic pull_lane,
    input wire logic [7:0] port_lo_out,
    input wire logic [7:0] port_hi_out,
    input wire logic [7:0] port_lo_oe_n,
    input wire logic [7:0] port_hi_oe_n,
    output logic [7:0] port_lo_in,
    output logic [7:0] port_hi_in,
    output logic slave_addr_strobe,
    output logic slave_data_strobe
);
    logic drv_en; // model drives the ports
    logic [15:0] drv_val; // value the model drives
    logic [15:0] dev_lvl; // device side, released bits pulled high
    // open drain with pull-ups: wired-and of both parties
    assign dev_lvl = {port_hi_out | port_hi_oe_n, port_lo_out | port_lo_oe_n};
    // a failing slave pulls its lane low
    assign {port_hi_in, port_lo_in} = dev_lvl
        & (drv_en ? drv_val : 16'hFFFF) & {15'h7FFF, !pull_lane};
    initial begin
        drv_en = 1'b0;
        drv_val = 16'hFFFF;
        slave_addr_strobe = 1'b1;
        slave_data_strobe = 1'b1;
    end
    // one address then one data transfer; hold = data strobe low cycles
    task automatic send(input logic [15:0] a, input logic [15:0] d,
                        input int hold);
        @(posedge clk);
        drv_val <= a; // address set up before the strobe
        drv_en <= 1'b1;
        @(posedge clk);
        slave_addr_strobe <= 1'b0;
        repeat (3) @(posedge clk);
        slave_addr_strobe <= 1'b1;
        drv_val <= d; // data set up before the strobe
        @(posedge clk);
        slave_data_strobe <= 1'b0;
        repeat (hold) @(posedge clk);
        slave_data_strobe <= 1'b1;
        drv_en <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : send
endmodule : eph_far_model

// ==== test/eph_program_handshake_tb.sv ====
// testbench: slave, config, refused and auto programming sessions
`timescale 1ns/1ps
module eph_program_handshake_tb;
    logic clk, nrst, ext_access_select, bad, pull_lane;
    logic [1:0] burn_mode_select;
    logic [7:0] port_lo_in, port_hi_in, port_lo_out, port_hi_out;
    logic [7:0] port_lo_oe_n, port_hi_oe_n;
    logic slave_addr_strobe, slave_data_strobe;
    logic master_addr_strobe, master_data_strobe;
    logic md_prev = 1'b1; // data strobe at the last negedge
    logic [15:0] image_addr, image_data, array_rdata;
    logic image_last, image_next, array_wr;
    eph_pkg::eph_req_t array_req;
    logic burn_active_n, burn_pass, byte_verify_ok, pulse_overrun_n;
    logic [15:0] img_a [0:4]; // image source contents
    logic [15:0] img_d [0:4];
    int n_img, seed, err_count, compares, n;
    int idx = 0, wr_cnt = 0, burn_cnt = 0;
    //------------------------------------------------------------------
    // clock, image source and array model
    //------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    assign image_addr = img_a[idx];
    assign image_data = img_d[idx];
    assign image_last = idx + 1 >= n_img; // word now offered is the final
    // array reads back what was written, one bit wrong when bad is set
    assign array_rdata = array_req.data ^ {15'h0000, bad};
    always @(posedge clk) begin
        if (image_next) idx <= idx + 1;
        else if (burn_mode_select != eph_pkg::MODE_AUTO) idx <= 0;
    end
    eph_program_handshake #(.PULSE_MAX(8), .PROG_TIME(4),
        .VERIFY_LANE(4'h0)) dut (.*);
    eph_far_model u_far (.clk(clk), .pull_lane(pull_lane),
        .port_lo_out(port_lo_out), .port_hi_out(port_hi_out),
        .port_lo_oe_n(port_lo_oe_n), .port_hi_oe_n(port_hi_oe_n),
        .port_lo_in(port_lo_in), .port_hi_in(port_hi_in),
        .slave_addr_strobe(slave_addr_strobe),
        .slave_data_strobe(slave_data_strobe));
    //------------------------------------------------------------------
    // tasks
    //------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic summarize();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    // bounded wait for the active indicator to reach a level
    task automatic wait_active(input logic v);
        int k;
        k = 0;
        while (burn_active_n !== v && k < 1000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 1000) begin
            err_count++;
            summarize();
        end
    endtask : wait_active
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    task automatic slave_word(input int hold, input logic b);
        logic [15:0] a;
        logic [15:0] d;
        a = 16'($random(seed));
        d = 16'($random(seed));
        bad <= b;
        u_far.send(a, d, hold);
        chk("req_addr", a, array_req.addr);
        chk("req_data", d, array_req.data);
        chk("verify", {15'h0000, !b}, {15'h0000, byte_verify_ok});
    endtask : slave_word
    task automatic auto_run(input int cnt, input logic fail);
        burn_mode_select <= 2'h3;
        repeat (3) @(posedge clk);
        // bit 0 set so a pulled lane always shows as a mismatch
        for (int i = 0; i < 5; i++) begin
            img_a[i] = 16'($random(seed));
            img_d[i] = 16'($random(seed)) | 16'h0001;
        end
        n_img <= cnt;
        pull_lane <= fail;
        @(posedge clk);
        burn_mode_select <= eph_pkg::MODE_AUTO;
        n = burn_cnt;
        wait_active(1'b0);
        wait_active(1'b1);
        chk("burns", 16'(cnt), 16'(burn_cnt - n));
        chk("auto_pass", {15'h0000, fail}, {15'h0000, burn_pass});
        @(posedge clk);
        pull_lane <= 1'b0;
    endtask : auto_run
    //------------------------------------------------------------------
    // monitor of the auto master and of array writes
    //------------------------------------------------------------------
    always @(negedge clk) begin
        if (burn_mode_select == eph_pkg::MODE_AUTO && nrst) begin
            if (!master_addr_strobe)
                chk("auto_addr", img_a[idx], {port_hi_out, port_lo_out});
            if (!master_data_strobe)
                chk("auto_data", img_d[idx], {port_hi_out, port_lo_out});
            if (md_prev && !master_data_strobe) burn_cnt++;
        end
        if (array_wr) wr_cnt++;
        md_prev = master_data_strobe;
    end
    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        seed = 79;
        err_count = 0;
        compares = 0;
        n_img = 0;
        nrst = 1'b0;
        ext_access_select = 1'b0;
        burn_mode_select = 2'h3;
        bad = 1'b0;
        pull_lane = 1'b0;
        for (int i = 0; i < 5; i++) begin
            img_a[i] = 16'h0000;
            img_d[i] = 16'h0000;
        end
        repeat (8) @(posedge clk);
        // strobes, active, pass, verify, overrun, write during reset
        chk("reset_pins", 16'h007A, {9'h000, master_addr_strobe,
            master_data_strobe, burn_active_n, burn_pass, byte_verify_ok,
            pulse_overrun_n, array_wr});
        nrst <= 1'b1;
        ext_access_select <= 1'b1;
        @(posedge clk);
        burn_mode_select <= eph_pkg::MODE_SLAVE;
        // good words, then a failing one last since its lane stays pulled
        for (int i = 0; i < 5; i++) begin
            slave_word(2, i == 4);
            chk("pass", {15'h0000, i != 4}, {15'h0000, burn_pass});
            chk("writes", 16'(i + 1), 16'(wr_cnt));
        end
        chk("lane_oe", 16'h0000, {15'h0000, port_lo_oe_n[0]});
        do_reset();
        bad <= 1'b0;
        slave_word(10, 1'b0);
        chk("overrun", 16'h0000, {15'h0000, pulse_overrun_n});
        slave_word(2, 1'b0);
        chk("overrun", 16'h0001, {15'h0000, pulse_overrun_n});
        burn_mode_select <= eph_pkg::MODE_CFG;
        slave_word(2, 1'b0);
        burn_mode_select <= 2'h3;
        n = wr_cnt;
        u_far.send(16'h1234, 16'h5678, 2);
        chk("refused", 16'(n), 16'(wr_cnt));
        do_reset();
        auto_run(3, 1'b0);
        auto_run(2, 1'b1);
        summarize();
    end
    // watchdog against a hang anywhere in the run
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule : eph_program_handshake_tb
